/* File: rtl/tdp_map.vh */
`ifndef TDP_MAP_VH
`define TDP_MAP_VH
// tap state codes, standard controller numbering
`define TDP_ST_EXIT2_DR   4'h0
`define TDP_ST_EXIT1_DR   4'h1
`define TDP_ST_SHIFT_DR   4'h2
`define TDP_ST_PAUSE_DR   4'h3
`define TDP_ST_SEL_IR     4'h4
`define TDP_ST_UPD_DR     4'h5
`define TDP_ST_CAP_DR     4'h6
`define TDP_ST_SEL_DR     4'h7
`define TDP_ST_EXIT2_IR   4'h8
`define TDP_ST_EXIT1_IR   4'h9
`define TDP_ST_SHIFT_IR   4'hA
`define TDP_ST_PAUSE_IR   4'hB
`define TDP_ST_IDLE       4'hC
`define TDP_ST_UPD_IR     4'hD
`define TDP_ST_CAP_IR     4'hE
`define TDP_ST_RESET      4'hF
// instruction codes
`define TDP_INS_SCAN_N    4'h2
`define TDP_INS_INTEST    4'hC
`define TDP_INS_TRISTATE_INSTR_ACTIVE     4'h7
`define TDP_INS_BYPASS    4'hF
`define TDP_INS_EXTEST    4'h0
// reset values
`define TDP_IR_RST        4'hF
`define TDP_SC_RST        4'h0
`endif

/* File: rtl/tdp_port.v */
`timescale 1ns/10ps
// Overview of operation
// - instruction output follows loaded instruction, updated on falling test clock in update-dr
// - scan chain number output updated on falling test clock in update-dr
// - tap state output changes on rising test clock
// - tristate indicator high while high-impedance instruction is loaded
// - external scan reset high in reset state or while test reset low
// - two non-overlapping phase clocks follow high and low test clock phases
// - serial data sent to external chain, returned data muxed onto test output
// - output enable low exactly while test output is driven
// - test reset low resets tap state, instruction, chain select and test output, but not the shift registers
// - breakpoint marks access; fetch halts only if it reaches execute
// - breakpointed data access halts after current instruction completes
// - receive-full flag high while receive buffer holds unread data
// - transmit-empty flag high while transmit buffer is empty
// - debug acknowledge high in debug state, low otherwise
// - debug enable low blocks breakpoint and request, forces acknowledge low
// - debug request halts after current instruction completes
// - two external condition inputs qualify watchpoint matching
// - range outputs follow watch unit match regardless of enable bits
`include "tdp_map.vh"
module tdp_port #(
  parameter SC_W = 4
) (
  input  wire            clk,
  input  wire            rst_b,
  input  wire            test_clock_in,
  input  wire            test_mode_select_in,
  input  wire            test_serial_in,
  input  wire            test_reset_n,
  output reg             test_serial_out,
  output reg             test_out_enable_n,
  output reg  [3:0]      tap_instr_out,
  output reg  [SC_W-1:0] scan_chain_select_out,
  output reg  [3:0]      tap_state_out,
  output reg             tristate_instr_active,
  output reg             ext_scan_reset_out,
  output reg             test_clk_high_phase,
  output reg             test_clk_low_phase,
  output reg             ext_chain_serial_out,
  input  wire            ext_chain_serial_return,
  input  wire            breakpoint_in,
  input  wire            debug_entry_request,
  input  wire            debug_features_enable,
  input  wire [1:0]      ext_condition_in,
  input  wire            instr_fetch,
  input  wire            access_valid,
  input  wire            instr_execute,
  input  wire            instr_complete,
  input  wire            debug_exit,
  input  wire            comms_rx_write,
  input  wire            comms_rx_read,
  input  wire            comms_tx_write,
  input  wire            comms_tx_read,
  input  wire [1:0]      watch_hit,
  input  wire [1:0]      watch_ext_care,
  input  wire [1:0]      watch_ext_value,
  output reg             debug_state_ack,
  output reg             comms_receive_full,
  output reg             comms_transmit_empty,
  output reg  [1:0]      watch_unit_match,
  output reg             core_halt_req
);

  // reset release
  reg rst_m_r, rst_s_r;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_r <= 1'b0;
      rst_s_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_s_r <= rst_m_r;
    end
  end
  wire rst_n = rst_s_r;

  // pin synchronisers
  reg [6:0] sy_m_r, sy_s_r;
  wire [6:0] sy_in = {test_clock_in, test_mode_select_in, test_serial_in, test_reset_n,
                      ext_chain_serial_return, breakpoint_in, debug_entry_request};
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sy_m_r <= 7'h00;
      sy_s_r <= 7'h00;
    end else begin
      sy_m_r <= sy_in;
      sy_s_r <= sy_m_r;
    end
  end
  wire tck_s  = sy_s_r[6];
  wire tms_s  = sy_s_r[5];
  wire tdi_s  = sy_s_r[4];
  wire trst_s = sy_s_r[3];
  wire ret_s  = sy_s_r[2];
  wire bkpt_s = sy_s_r[1];
  wire dreq_s = sy_s_r[0];
  reg [1:0] den_m_r, den_s_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      den_m_r <= 2'b00;
      den_s_r <= 2'b00;
    end else begin
      den_m_r <= {debug_features_enable, 1'b0};
      den_s_r <= den_m_r;
    end
  end
  wire den_s = den_s_r[1];

  // test clock edges
  reg tck_d_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      tck_d_r <= 1'b0;
    else
      tck_d_r <= tck_s;
  end
  wire tck_rise = tck_s & ~tck_d_r;
  wire tck_fall = ~tck_s & tck_d_r;

  // tap state machine
  reg  [3:0] st_r;
  reg  [3:0] st_nxt;
  always @* begin
    case (st_r)
      `TDP_ST_RESET:    st_nxt = tms_s ? `TDP_ST_RESET    : `TDP_ST_IDLE;
      `TDP_ST_IDLE:     st_nxt = tms_s ? `TDP_ST_SEL_DR   : `TDP_ST_IDLE;
      `TDP_ST_SEL_DR:   st_nxt = tms_s ? `TDP_ST_SEL_IR   : `TDP_ST_CAP_DR;
      `TDP_ST_CAP_DR:   st_nxt = tms_s ? `TDP_ST_EXIT1_DR : `TDP_ST_SHIFT_DR;
      `TDP_ST_SHIFT_DR: st_nxt = tms_s ? `TDP_ST_EXIT1_DR : `TDP_ST_SHIFT_DR;
      `TDP_ST_EXIT1_DR: st_nxt = tms_s ? `TDP_ST_UPD_DR   : `TDP_ST_PAUSE_DR;
      `TDP_ST_PAUSE_DR: st_nxt = tms_s ? `TDP_ST_EXIT2_DR : `TDP_ST_PAUSE_DR;
      `TDP_ST_EXIT2_DR: st_nxt = tms_s ? `TDP_ST_UPD_DR   : `TDP_ST_SHIFT_DR;
      `TDP_ST_UPD_DR:   st_nxt = tms_s ? `TDP_ST_SEL_DR   : `TDP_ST_IDLE;
      `TDP_ST_SEL_IR:   st_nxt = tms_s ? `TDP_ST_RESET    : `TDP_ST_CAP_IR;
      `TDP_ST_CAP_IR:   st_nxt = tms_s ? `TDP_ST_EXIT1_IR : `TDP_ST_SHIFT_IR;
      `TDP_ST_SHIFT_IR: st_nxt = tms_s ? `TDP_ST_EXIT1_IR : `TDP_ST_SHIFT_IR;
      `TDP_ST_EXIT1_IR: st_nxt = tms_s ? `TDP_ST_UPD_IR   : `TDP_ST_PAUSE_IR;
      `TDP_ST_PAUSE_IR: st_nxt = tms_s ? `TDP_ST_EXIT2_IR : `TDP_ST_PAUSE_IR;
      `TDP_ST_EXIT2_IR: st_nxt = tms_s ? `TDP_ST_UPD_IR   : `TDP_ST_SHIFT_IR;
      `TDP_ST_UPD_IR:   st_nxt = tms_s ? `TDP_ST_SEL_DR   : `TDP_ST_IDLE;
      default:          st_nxt = `TDP_ST_RESET;
    endcase
  end

  // shift registers, instruction and chain select
  reg [3:0]      ir_sh_r, ir_r;
  reg [SC_W-1:0] sc_sh_r, sc_r;
  reg            byp_r;
  wire jtag_rst = ~trst_s;
  wire scan_n   = (ir_r == `TDP_INS_SCAN_N);
  wire ext_sel  = (ir_r == `TDP_INS_EXTEST) | (ir_r == `TDP_INS_INTEST);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r    <= `TDP_ST_RESET;
      ir_sh_r <= 4'h0;
      ir_r    <= `TDP_IR_RST;
      sc_sh_r <= {SC_W{1'b0}};
      sc_r    <= {SC_W{1'b0}};
      byp_r   <= 1'b0;
    end else if (jtag_rst) begin
      st_r    <= `TDP_ST_RESET;
      ir_r    <= `TDP_IR_RST;
      sc_r    <= {SC_W{1'b0}};
    end else begin
      if (tck_rise) begin
        st_r <= st_nxt;
        if (st_r == `TDP_ST_RESET)
          ir_r <= `TDP_IR_RST;
        if (st_r == `TDP_ST_CAP_IR)
          ir_sh_r <= 4'h1;
        if (st_r == `TDP_ST_SHIFT_IR)
          ir_sh_r <= {tdi_s, ir_sh_r[3:1]};
        if (st_r == `TDP_ST_SHIFT_DR) begin
          byp_r <= tdi_s;
          if (scan_n)
            sc_sh_r <= {tdi_s, sc_sh_r[SC_W-1:1]};
        end
      end
      // update on the falling test clock edge
      if (tck_fall && st_r == `TDP_ST_UPD_IR)
        ir_r <= ir_sh_r;
      if (tck_fall && st_r == `TDP_ST_UPD_DR && scan_n)
        sc_r <= sc_sh_r;
    end
  end

  // tap side outputs
  wire shifting = (st_r == `TDP_ST_SHIFT_DR) | (st_r == `TDP_ST_SHIFT_IR);
  // serial source select: instruction, chain number, external chain or bypass
  // the external chain is only looked at for the boundary instructions
  reg  tdo_nxt;
  always @* begin
    if (st_r == `TDP_ST_SHIFT_IR)
      tdo_nxt = ir_sh_r[0];
    else if (scan_n)
      tdo_nxt = sc_sh_r[0];
    else if (ext_sel)
      tdo_nxt = ret_s;
    else
      tdo_nxt = byp_r;
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tap_state_out         <= `TDP_ST_RESET;
      tap_instr_out         <= `TDP_IR_RST;
      scan_chain_select_out <= {SC_W{1'b0}};
      tristate_instr_active <= 1'b0;
      ext_scan_reset_out    <= 1'b1;
      ext_chain_serial_out  <= 1'b0;
    end else begin
      tap_state_out         <= st_r;
      scan_chain_select_out <= sc_r;
      tristate_instr_active <= (ir_r == `TDP_INS_TRISTATE_INSTR_ACTIVE);
      ext_scan_reset_out    <= (st_r == `TDP_ST_RESET) | jtag_rst;
      ext_chain_serial_out  <= tdi_s;
      // exported instruction moves only on the update-dr fall or on test reset
      if (jtag_rst)
        tap_instr_out <= `TDP_IR_RST;
      else if (tck_fall && st_r == `TDP_ST_UPD_DR)
        tap_instr_out <= ir_r;
    end
  end

  // phase clocks, both low for one cycle around each test clock edge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      test_clk_high_phase <= 1'b0;
      test_clk_low_phase  <= 1'b0;
    end else begin
      test_clk_high_phase <= tck_s & tck_d_r;
      test_clk_low_phase  <= ~tck_s & ~tck_d_r;
    end
  end

  // serial output and its enable, changed on the falling test clock
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      test_serial_out   <= 1'b0;
      test_out_enable_n <= 1'b1;
    end else if (jtag_rst) begin
      test_serial_out   <= 1'b0;
      test_out_enable_n <= 1'b1;
    end else if (tck_fall) begin
      test_serial_out   <= shifting ? tdo_nxt : 1'b0;
      test_out_enable_n <= ~shifting;
    end
  end

  // debug entry: gated requests and pending breakpoints
  wire bkpt_g = bkpt_s & den_s;
  wire dreq_g = dreq_s & den_s;
  reg  fetch_mark_r, data_mark_r, dbg_r;
  // halt causes, each already gated by debug enable
  wire fetch_hit  = fetch_mark_r & instr_execute;
  wire data_hit   = data_mark_r & instr_complete;
  wire req_hit    = dreq_g & instr_complete;
  wire halt_cause = fetch_hit | data_hit | req_hit;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_mark_r <= 1'b0;
      data_mark_r  <= 1'b0;
      dbg_r        <= 1'b0;
    end else begin
      // fetch mark is held until the next execute, which clears it
      if (bkpt_g && access_valid && instr_fetch)
        fetch_mark_r <= 1'b1;
      else if (instr_execute)
        fetch_mark_r <= 1'b0;
      if (bkpt_g && access_valid && !instr_fetch)
        data_mark_r <= 1'b1;
      else if (instr_complete)
        data_mark_r <= 1'b0;
      if (!den_s)
        dbg_r <= 1'b0;
      else if (halt_cause)
        dbg_r <= 1'b1;
      else if (debug_exit)
        dbg_r <= 1'b0;
    end
  end

  // comms flags and watch match, set wins over clear
  reg rx_full_r, tx_full_r;
  // next flag values, a write with a read in one cycle sets the flag
  wire rx_full_nxt = comms_rx_write | (rx_full_r & ~comms_rx_read);
  wire tx_full_nxt = comms_tx_write | (tx_full_r & ~comms_tx_read);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_full_r <= 1'b0;
      tx_full_r <= 1'b0;
    end else begin
      rx_full_r <= rx_full_nxt;
      tx_full_r <= tx_full_nxt;
    end
  end

  // watch match, one slice per unit, no enable bit involved
  wire [1:0] watch_q;
  genvar wu;
  generate
    for (wu = 0; wu < 2; wu = wu + 1) begin : g_watch
      // care bit set and a differing condition masks the hit
      wire cond_miss = watch_ext_care[wu] & (ext_condition_in[wu] ^ watch_ext_value[wu]);
      assign watch_q[wu] = watch_hit[wu] & ~cond_miss;
    end
  endgenerate

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      debug_state_ack      <= 1'b0;
      comms_receive_full   <= 1'b0;
      comms_transmit_empty <= 1'b1;
      watch_unit_match     <= 2'b00;
      core_halt_req        <= 1'b0;
    end else begin
      debug_state_ack      <= dbg_r & den_s;
      core_halt_req        <= dbg_r & den_s;
      comms_receive_full   <= rx_full_r;
      comms_transmit_empty <= ~tx_full_r;
      watch_unit_match     <= watch_q;
    end
  end

endmodule

/* File: bench/tdp_port_monitor.sv */
`timescale 1ns/10ps
`include "tdp_map.vh"
module tdp_port_monitor #(
  parameter SC_W = 4
) (
  input logic            clk,
  input logic            rst_b,
  input logic            test_clock_in,
  input logic            test_reset_n,
  input logic            debug_features_enable,
  input logic            debug_entry_request,
  input logic            instr_complete,
  input logic            comms_rx_write,
  input logic [3:0]      tap_state_out,
  input logic [3:0]      tap_instr_out,
  input logic [SC_W-1:0] scan_chain_select_out,
  input logic            tristate_instr_active,
  input logic            ext_scan_reset_out,
  input logic            test_clk_high_phase,
  input logic            test_clk_low_phase,
  input logic            test_out_enable_n,
  input logic            debug_state_ack,
  input logic            comms_receive_full
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // steady test clock levels and a held debug request
  sequence tck_hi; test_clock_in [*8]; endsequence
  sequence tck_lo; (!test_clock_in) [*8]; endsequence
  sequence req_held; (debug_features_enable && debug_entry_request) [*6]; endsequence
  // phase clocks
  AST_PH_NOVL: assert property (!(test_clk_high_phase && test_clk_low_phase)) else $error("phases overlap");
  AST_PH_HI: assert property (tck_hi |-> test_clk_high_phase && !test_clk_low_phase)
    else $error("high phase wrong");
  AST_PH_LO: assert property (tck_lo |-> test_clk_low_phase && !test_clk_high_phase)
    else $error("low phase wrong");
  // controller state, instruction and chain outputs
  AST_TRST: assert property ((!test_reset_n) [*6] |-> ext_scan_reset_out && tap_state_out == `TDP_ST_RESET)
    else $error("test reset ignored");
  AST_ST_RISE: assert property (disable iff (!rst_b || !test_reset_n) !$stable(tap_state_out) |-> test_clock_in)
    else $error("state moved off the rising test clock");
  AST_IR_UPD: assert property (disable iff (!rst_b || !test_reset_n)
    !$stable(tap_instr_out) |-> tap_state_out == `TDP_ST_UPD_DR) else $error("instruction moved outside update");
  AST_SC_UPD: assert property (disable iff (!rst_b || !test_reset_n)
    !$stable(scan_chain_select_out) |-> tap_state_out == `TDP_ST_UPD_DR) else $error("chain moved outside update");
  AST_TRISTATE_INSTR_ACTIVE: assert property ((tap_instr_out == `TDP_INS_TRISTATE_INSTR_ACTIVE) [*2] |-> tristate_instr_active)
    else $error("tristate flag missing");
  AST_TDO_EN: assert property ($fell(test_out_enable_n) |-> tap_state_out inside {`TDP_ST_SHIFT_DR, `TDP_ST_SHIFT_IR})
    else $error("output enabled outside shift");
  // debug and comms
  AST_ACK_REQ: assert property (req_held ##0 instr_complete |-> ##[1:4] debug_state_ack)
    else $error("request did not halt");
  AST_ACK_OFF: assert property ((!debug_features_enable) [*6] |-> !debug_state_ack) else $error("ack while disabled");
  AST_RX_FULL: assert property (comms_rx_write |-> ##[1:2] comms_receive_full) else $error("receive flag late");
endmodule
bind tdp_port tdp_port_monitor #(.SC_W(SC_W)) tdp_port_monitor_i (.*);

/* File: bench/tdp_jtag_host.sv */
`timescale 1ns/10ps
module tdp_jtag_host (
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic ext_ret,
  input  logic ext_out
);
  // idle: clock parked low, mode select and data pulled high
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    ext_ret = 1'b0;
  end
  // one 80 ns test clock period, pins set in the low phase
  task step(input logic m, input logic d);
    tms = m;
    tdi = d;
    #20 tck = 1'b1;
    #40 tck = 1'b0;
    #20;
  endtask
  // one-bit external scan chain
  always @(posedge tck) ext_ret <= ext_out;
endmodule

/* File: bench/tdp_port_test.sv */
`timescale 1ns/10ps
`include "tdp_map.vh"
module tdp_port_test;
  logic       clk, rst_b, test_clock_in, test_mode_select_in, test_serial_in, test_reset_n, breakpoint_in;
  logic       ext_chain_serial_out, ext_chain_serial_return, debug_entry_request, debug_features_enable;
  logic       instr_fetch, access_valid, instr_execute, debug_state_ack, test_out_enable_n;
  logic       tristate_instr_active, ext_scan_reset_out, comms_receive_full, comms_transmit_empty;
  logic [1:0] ext_condition_in, watch_hit, watch_ext_care, watch_ext_value, watch_unit_match;
  logic [3:0] tap_instr_out, scan_chain_select_out, tap_state_out, exp_last, st_last, sc_v;
  logic [5:0] pl;
  logic [3:0] exp_q[$];
  integer     seed, fail_count, check_count, i;
  tdp_port tdp_port_i (.*, .test_serial_out(), .test_clk_high_phase(), .test_clk_low_phase(), .core_halt_req(),
    .instr_complete(pl[0]), .debug_exit(pl[1]), .comms_rx_write(pl[2]), .comms_rx_read(pl[3]),
    .comms_tx_write(pl[4]), .comms_tx_read(pl[5]));
  tdp_jtag_host tdp_jtag_host_i (.tck(test_clock_in), .tms(test_mode_select_in), .tdi(test_serial_in),
    .ext_ret(ext_chain_serial_return), .ext_out(ext_chain_serial_out));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task chk(input logic [11:0] g, input logic [11:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task pulse(input integer b);
    pl[b] = 1'b1;
    tick(1);
    pl[b] = 1'b0;
  endtask
  // one controller step, noting the state expected after it
  task mv(input logic t, input logic d, input logic [3:0] e);
    if (e !== exp_last) exp_q.push_back(e);
    exp_last = e;
    tdp_jtag_host_i.step(t, d);
  endtask
  // full instruction or data scan, lsb first, back to idle
  task scan(input logic irs, input logic [3:0] v);
    mv(1'b1, 1'b0, `TDP_ST_SEL_DR);
    if (irs) mv(1'b1, 1'b0, `TDP_ST_SEL_IR);
    mv(1'b0, 1'b0, irs ? `TDP_ST_CAP_IR : `TDP_ST_CAP_DR);
    mv(1'b0, 1'b0, irs ? `TDP_ST_SHIFT_IR : `TDP_ST_SHIFT_DR);
    for (i = 0; i < 4; i++)
      mv(i == 3, v[i], i < 3 ? (irs ? `TDP_ST_SHIFT_IR : `TDP_ST_SHIFT_DR) : (irs ? `TDP_ST_EXIT1_IR : `TDP_ST_EXIT1_DR));
    mv(1'b1, 1'b0, irs ? `TDP_ST_UPD_IR : `TDP_ST_UPD_DR);
    mv(1'b0, 1'b0, `TDP_ST_IDLE);
  endtask
  // debug entry attempt: no halt before the completion pulse
  task dbg(input logic e, input logic r, input logic b);
    debug_features_enable = e;
    debug_entry_request = r;
    breakpoint_in = b;
    access_valid = b;
    tick(6);
    chk(debug_state_ack, 1'b0);
    pulse(0);
    {debug_entry_request, breakpoint_in, access_valid} = 3'b000;
    tick(4);
  endtask
  // state watcher takes the oldest note on every change
  always @(posedge clk) begin
    if (rst_b && tap_state_out !== st_last)
      chk(tap_state_out, exp_q.size() ? exp_q.pop_front() : ~tap_state_out);
    st_last = tap_state_out;
  end
  initial begin
    #200000;
    fail_count++;
    summarize;
  end
  initial begin
    {rst_b, breakpoint_in, debug_entry_request, instr_fetch, access_valid, instr_execute, pl} = '0;
    {watch_hit, watch_ext_care, watch_ext_value, ext_condition_in} = '0;
    {test_reset_n, debug_features_enable} = 2'b11;
    {seed, fail_count, check_count} = {32'd36, 32'd0, 32'd0};
    exp_last = `TDP_ST_RESET;
    tick(20);
    rst_b = 1'b1;
    tick(4);
    chk({tap_state_out, tap_instr_out}, {`TDP_ST_RESET, `TDP_IR_RST});
    chk({ext_scan_reset_out, test_out_enable_n, comms_transmit_empty, comms_receive_full}, 4'b1110);
    mv(1'b0, 1'b0, `TDP_ST_IDLE);
    sc_v = $random(seed);
    scan(1'b1, `TDP_INS_SCAN_N);
    scan(1'b0, sc_v);
    chk({tristate_instr_active, tap_instr_out, scan_chain_select_out}, {1'b0, `TDP_INS_SCAN_N, sc_v});
    scan(1'b1, `TDP_INS_TRISTATE_INSTR_ACTIVE);
    scan(1'b0, ~sc_v);
    chk({tristate_instr_active, tap_instr_out, scan_chain_select_out}, {1'b1, `TDP_INS_TRISTATE_INSTR_ACTIVE, sc_v});
    exp_q.push_back(`TDP_ST_RESET);
    exp_last = `TDP_ST_RESET;
    test_reset_n = 1'b0;
    tick(20);
    chk({ext_scan_reset_out, tap_instr_out, scan_chain_select_out}, {1'b1, `TDP_IR_RST, `TDP_SC_RST});
    test_reset_n = 1'b1;
    mv(1'b0, 1'b0, `TDP_ST_IDLE);
    chk(ext_scan_reset_out, 1'b0);
    dbg(1'b1, 1'b1, 1'b0);
    chk(debug_state_ack, 1'b1);
    pulse(1);
    tick(4);
    dbg(1'b1, 1'b0, 1'b1);
    chk(debug_state_ack, 1'b1);
    pulse(1);
    tick(4);
    dbg(1'b0, 1'b1, 1'b1);
    chk(debug_state_ack, 1'b0);
    debug_features_enable = 1'b1;
    for (i = 2; i < 6; i++) begin
      pulse(i);
      tick(2);
      chk({comms_receive_full, comms_transmit_empty}, {i == 2, i != 4});
    end
    for (i = 0; i < 8; i++) begin
      {watch_hit, watch_ext_care, watch_ext_value, ext_condition_in} = $random(seed);
      tick(3);
      chk(watch_unit_match, watch_hit & ~(watch_ext_care & (ext_condition_in ^ watch_ext_value)));
    end
    for (i = 0; i < 100 && exp_q.size() != 0; i++) tick(1);
    chk(exp_q.size(), 0);
    summarize;
  end
  task summarize;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
endmodule
